// ### common/pep_pkg.sv
// pep_pkg: constants and carrier types for the parallel eeprom page-write host.
// assumes a 20 MHz mclk and an external byte-wide eeprom with 9 address lines.
package pep_pkg;
  // ****************************************************************
  // widths and timing
  // ****************************************************************
  localparam int unsigned ADDR_W = 9;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PAGE_LO_W = 4;
  localparam int unsigned PAGE_MAX = 16;
  localparam int unsigned CLK_PERIOD_NS = 50;
  // strobe pulse width, made well above the noise filter and min pulse
  localparam int unsigned STROBE_NS = 150;
  localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // data settle time before sampling a read
  localparam int unsigned READ_NS = 300;
  localparam int unsigned READ_CYC = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // gap between byte loads, longest time, rounded down
  localparam int unsigned LOAD_WIN_NS = 20000;
  localparam int unsigned LOAD_GAP_NS = 15000;
  localparam int unsigned LOAD_GAP_CYC = LOAD_GAP_NS / CLK_PERIOD_NS;
  // wait after the gap closes, so polling starts only once the window has lapsed
  localparam int unsigned LOAD_WIN_CYC = LOAD_WIN_NS / CLK_PERIOD_NS;
  // power-up to first write, least time, rounded up
  localparam int unsigned PUW_MS = 5;
  localparam int unsigned PUW_CYC_DEF = (PUW_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // programming time limit before polling gives up
  localparam int unsigned PROG_MAX_MS = 10;
  localparam int unsigned PROG_MAX_CYC_DEF = (PROG_MAX_MS * 1000000) / CLK_PERIOD_NS;
  localparam int unsigned CNT_W = 24;
  localparam logic [CNT_W-1:0] CNT_RST = 24'h000000;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic cs_n;
    logic oe_n;
    logic we_n;
  } pep_ctl_t;

  localparam pep_ctl_t CTL_IDLE = 3'h7;

  typedef struct packed {
    logic write;
    logic last;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pep_req_t;

  typedef struct packed {
    logic done;
    logic timeout;
    logic [DATA_W-1:0] data;
  } pep_rsp_t;

  typedef enum logic [2:0] {
    ST_PWRUP = 3'h0,
    ST_IDLE = 3'h1,
    ST_WSTRB = 3'h2,
    ST_WGAP = 3'h3,
    ST_READ = 3'h4,
    ST_POLL = 3'h5,
    ST_PGAP = 3'h6
  } pep_state_t;
endpackage : pep_pkg

// ### src/pep_sync.sv
// pep_sync: two-flop synchroniser for a bus of pin inputs.
// assumes the inputs are asynchronous to mclk.
`timescale 1ns/10ps
module pep_sync
  import pep_pkg::*;
#(
  parameter int unsigned W = 8
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);
  logic [W-1:0] meta_q;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule : pep_sync

// ### src/pep_host.sv
// pep_host: host controller that drives a parallel eeprom's pins.
// assumes one device on the pins, request port on mclk, data pins
// resolved by the bench from data_oe_n.
`timescale 1ns/10ps
module pep_host
  import pep_pkg::*;
#(
  parameter int unsigned PUW_CYC = PUW_CYC_DEF,
  parameter int unsigned PROG_MAX_CYC = PROG_MAX_CYC_DEF
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_valid,
  input wire pep_req_t req,
  output logic req_ready,
  output pep_rsp_t rsp,
  output logic [ADDR_W-1:0] addr_in,
  output pep_ctl_t ctl,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic [DATA_W-1:0] data_lines
);
  // ****************************************************************
  // state
  // ****************************************************************
  pep_state_t state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic [CNT_W-1:0] prog_q, prog_d;
  logic [4:0] nbytes_q, nbytes_d;
  logic last_q, last_d;
  logic [ADDR_W-PAGE_LO_W-1:0] page_q, page_d;
  logic [DATA_W-1:0] data_sync;
  logic [ADDR_W-1:0] addr_d;
  pep_ctl_t ctl_d;
  logic [DATA_W-1:0] dout_d;
  logic oe_n_d, rdy_d;
  pep_rsp_t rsp_d;

  pep_sync #(.W(DATA_W)) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din(data_lines),
    .dout(data_sync)
  );

  // ****************************************************************
  // decode
  // ****************************************************************
  wire cnt_done = (cnt_q == CNT_RST);
  wire [CNT_W-1:0] cnt_dec = cnt_q - 24'h000001;
  wire [CNT_W-1:0] strobe_ld = CNT_W'(STROBE_CYC);
  wire [CNT_W-1:0] read_ld = CNT_W'(READ_CYC);
  wire [CNT_W-1:0] gap_ld = CNT_W'(LOAD_GAP_CYC);
  wire [CNT_W-1:0] pgap_ld = CNT_W'(READ_CYC);
  wire [CNT_W-1:0] win_ld = CNT_W'(LOAD_WIN_CYC);
  // ready is registered, so it must not promise a take on the closing cycle
  wire gap_open = (cnt_q > 24'h000001);
  wire [ADDR_W-PAGE_LO_W-1:0] req_page = req.addr[ADDR_W-1:PAGE_LO_W];
  wire same_page = (req_page == page_q);
  wire page_full = (nbytes_q == 5'(PAGE_MAX));
  wire next_ok = req_valid && req.write && same_page && !page_full;
  wire poll_match = (data_sync[DATA_W-1] == data_out[DATA_W-1]);
  wire prog_over = (prog_q == CNT_RST);

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_done ? cnt_q : cnt_dec;
    prog_d = prog_over ? prog_q : prog_q - 24'h000001;
    nbytes_d = nbytes_q;
    last_d = last_q;
    page_d = page_q;
    addr_d = addr_in;
    ctl_d = CTL_IDLE;
    dout_d = data_out;
    oe_n_d = 1'b1;
    rdy_d = 1'b0;
    rsp_d = '0;
    unique case (state_q)
      ST_PWRUP: begin
        if (cnt_done) begin
          state_d = ST_IDLE;
          rdy_d = 1'b1;
        end
      end
      ST_IDLE: begin
        rdy_d = 1'b1;
        if (req_valid) begin
          rdy_d = 1'b0;
          addr_d = req.addr;
          if (req.write) begin
            dout_d = req.data;
            oe_n_d = 1'b0;
            ctl_d = '{cs_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
            page_d = req_page;
            last_d = req.last;
            nbytes_d = 5'h01;
            cnt_d = strobe_ld;
            state_d = ST_WSTRB;
          end else begin
            ctl_d = '{cs_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
            cnt_d = read_ld;
            state_d = ST_READ;
          end
        end
      end
      ST_WSTRB: begin
        oe_n_d = 1'b0;
        ctl_d = '{cs_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
        if (cnt_done) begin
          ctl_d = CTL_IDLE;
          cnt_d = gap_ld;
          state_d = ST_WGAP;
          rdy_d = next_ok && !last_q;
        end
      end
      ST_WGAP: begin
        oe_n_d = 1'b0;
        rdy_d = next_ok && !last_q && gap_open;
        if (req_valid && req_ready) begin
          rdy_d = 1'b0;
          addr_d = req.addr;
          dout_d = req.data;
          last_d = req.last;
          ctl_d = '{cs_n: 1'b0, oe_n: 1'b1, we_n: 1'b0};
          nbytes_d = nbytes_q + 5'h01;
          cnt_d = strobe_ld;
          state_d = ST_WSTRB;
        end else if (cnt_done || page_full || last_q) begin
          rdy_d = 1'b0;
          oe_n_d = 1'b1;
          prog_d = CNT_W'(PROG_MAX_CYC);
          // polling inside the window would see stale true data
          cnt_d = win_ld;
          state_d = ST_PGAP;
        end
      end
      ST_READ: begin
        ctl_d = '{cs_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
        if (cnt_done) begin
          ctl_d = CTL_IDLE;
          rsp_d = '{done: 1'b1, timeout: 1'b0, data: data_sync};
          rdy_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_PGAP: begin
        if (cnt_done) begin
          ctl_d = '{cs_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
          cnt_d = read_ld;
          state_d = ST_POLL;
        end
      end
      ST_POLL: begin
        ctl_d = '{cs_n: 1'b0, oe_n: 1'b0, we_n: 1'b1};
        if (cnt_done) begin
          ctl_d = CTL_IDLE;
          if (poll_match || prog_over) begin
            rsp_d = '{done: 1'b1, timeout: !poll_match, data: data_sync};
            rdy_d = 1'b1;
            state_d = ST_IDLE;
          end else begin
            cnt_d = pgap_ld;
            state_d = ST_PGAP;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_PWRUP;
      cnt_q <= CNT_W'(PUW_CYC);
      prog_q <= CNT_RST;
      nbytes_q <= 5'h00;
      last_q <= 1'b0;
      page_q <= '0;
      addr_in <= '0;
      ctl <= CTL_IDLE;
      data_out <= '0;
      data_oe_n <= 1'b1;
      req_ready <= 1'b0;
      rsp <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      prog_q <= prog_d;
      nbytes_q <= nbytes_d;
      last_q <= last_d;
      page_q <= page_d;
      addr_in <= addr_d;
      ctl <= ctl_d;
      data_out <= dout_d;
      data_oe_n <= oe_n_d;
      req_ready <= rdy_d;
      rsp <= rsp_d;
    end
  end
endmodule : pep_host

// ### tb/pep_dev_model.sv
// pep_dev_model: behavioural byte-wide eeprom on the host pins.
// assumes host pins change on mclk; window and programming in cycles.
`timescale 1ns/10ps
module pep_dev_model
  import pep_pkg::*;
#(
  parameter int WIN_CYC = 400,
  parameter int PROG_CYC = 200
) (
  input wire logic mclk,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire pep_ctl_t ctl,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe_n,
  output logic [DATA_W-1:0] data_lines
);
  logic [DATA_W-1:0] mem [512];
  logic [DATA_W-1:0] last_v = 8'h00;
  logic [ADDR_W-1:0] a_lat = 9'h000;
  logic [ADDR_W-1:0] a_last = 9'h000;
  logic wa_p = 1'b0;
  logic [DATA_W-1:0] d_lat = 8'h00;
  int win = 0;
  int prog = 0;
  int viol = 0;
  wire rd = !ctl.cs_n && !ctl.oe_n && ctl.we_n;
  // write active while select and strobe are low with output drive high
  wire wa = !ctl.cs_n && !ctl.we_n && ctl.oe_n;
  wire [7:0] rv = mem[addr_in] ^ {prog > 0 && addr_in == a_last, 7'h00};
  // released lines show the inverse of the last level
  assign data_lines = !data_oe_n ? data_out : rd ? rv : ~last_v;
  always @(posedge mclk) begin
    last_v <= data_lines;
    wa_p <= wa;
    if (wa) d_lat <= data_lines;
    if (!wa_p && wa) a_lat <= addr_in;
    if (wa_p && !wa) begin
      if (prog > 0) viol <= viol + 1;
      else begin
        mem[a_lat] <= d_lat;
        a_last <= a_lat;
        win <= WIN_CYC;
      end
    end else if (win > 0) begin
      win <= win - 1;
      if (win == 1) prog <= PROG_CYC;
    end else if (prog > 0) prog <= prog - 1;
  end
endmodule : pep_dev_model

// ### tb/pep_host_assertions.sv
// pep_host_assertions: pin and handshake checks on the host ports.
// assumes binding into pep_host.
`timescale 1ns/10ps
module pep_host_assertions
  import pep_pkg::*;
#(
  parameter int unsigned PUW_CYC = 10
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic req_ready,
  input wire pep_rsp_t rsp,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire pep_ctl_t ctl,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic [CNT_W-1:0] pw_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pw_q <= CNT_RST;
    else if (pw_q < CNT_W'(PUW_CYC)) pw_q <= pw_q + 24'h000001;
  end
  sequence rd_start; $fell(ctl.oe_n); endsequence
  sequence wr_start; $fell(ctl.we_n); endsequence
  a_reset_idle: assert property ($rose(rst_n) |-> ctl == CTL_IDLE && data_oe_n)
    else $error("pins not idle after reset");
  a_pwrup_wait: assert property (pw_q < CNT_W'(PUW_CYC - 1) |-> !req_ready)
    else $error("request taken before power-up delay");
  a_write_mode: assert property (!ctl.we_n |-> ctl.oe_n && !ctl.cs_n)
    else $error("strobe without select or with output drive");
  a_read_float: assert property (!ctl.oe_n |-> data_oe_n && ctl.we_n)
    else $error("host drives data during read");
  a_select_access: assert property (ctl.cs_n |-> ctl.oe_n && ctl.we_n)
    else $error("access without select");
  a_strobe_width: assert property (wr_start |-> !ctl.we_n [*4] ##1 ctl.we_n)
    else $error("strobe width wrong");
  a_write_hold: assert property (!ctl.we_n && !$fell(ctl.we_n) |->
    $stable(addr_in) && $stable(data_out) && !data_oe_n)
    else $error("address or data moved under strobe");
  a_read_span: assert property (rd_start |-> !ctl.oe_n [*6] ##[1:2] ctl == CTL_IDLE)
    else $error("read length wrong");
  a_read_end: assert property ($rose(ctl.oe_n) |-> ctl.cs_n)
    else $error("read ended with select still low");
  a_done_pulse: assert property (rsp.done |=> !rsp.done)
    else $error("done longer than one cycle");
endmodule : pep_host_assertions
bind pep_host pep_host_assertions #(.PUW_CYC(PUW_CYC)) chk_u (.mclk, .rst_n, .req_ready,
  .rsp, .addr_in, .ctl, .data_out, .data_oe_n);

// ### tb/pep_host_tb.sv
// pep_host_tb: directed bench for the eeprom page-write host.
// assumes pep_dev_model on the pins, short power-up delay.
`timescale 1ns/10ps
module pep_host_tb
  import pep_pkg::*;
();
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  pep_req_t req = '0;
  logic req_ready, data_oe_n;
  pep_rsp_t rsp;
  pep_ctl_t ctl;
  logic [ADDR_W-1:0] addr_in;
  logic [DATA_W-1:0] data_out, data_lines, rd_v;
  int errors = 0;
  int n_checks = 0;
  int wt;
  pep_host #(.PUW_CYC(10), .PROG_MAX_CYC(5000)) dut_u (.mclk, .rst_n, .req_valid, .req,
    .req_ready, .rsp, .addr_in, .ctl, .data_out, .data_oe_n, .data_lines);
  pep_dev_model #(.WIN_CYC(400), .PROG_CYC(200)) dev_u (.mclk, .addr_in, .ctl, .data_out,
    .data_oe_n, .data_lines);
  initial forever #25 mclk = ~mclk;
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  task automatic send(input logic w, input logic l, input logic [8:0] a, input logic [7:0] d);
    wt = 0;
    @(negedge mclk);
    req_valid = 1'b1;
    req = '{w, l, a, d};
    while (req_ready !== 1'b1 && wt < 9000) begin
      @(negedge mclk);
      wt++;
    end
    if (wt == 9000) chk(8'h01, 8'h00);
    if (wt == 9000) summarize();
    @(negedge mclk);
    req_valid = 1'b0;
  endtask : send
  task automatic wait_done();
    int n;
    for (n = 0; n < 9000 && rsp.done !== 1'b1; n++) @(negedge mclk);
    if (n == 9000) chk(8'h01, 8'h00);
    if (n == 9000) summarize();
    rd_v = rsp.data;
    chk(rsp.timeout, 1'b0);
  endtask : wait_done
  task automatic rd(input logic [8:0] a, input logic [7:0] e);
    send(1'b0, 1'b1, a, 8'h00);
    wait_done();
    chk(rd_v, e);
  endtask : rd
  task automatic t_power();
    int n;
    for (n = 0; req_ready !== 1'b1 && n < 100; n++) begin
      chk(ctl, CTL_IDLE);
      @(negedge mclk);
    end
    chk(n >= 10, 1'b1);
    $display("t_power done");
  endtask : t_power
  task automatic t_byte();
    send(1'b1, 1'b1, 9'h025, 8'ha5);
    wait_done();
    chk(dev_u.prog == 0, 1'b1);
    chk(dev_u.mem[9'h025], 8'ha5);
    rd(9'h025, 8'ha5);
    $display("t_byte done");
  endtask : t_byte
  task automatic t_page();
    for (int i = 0; i < 16; i++) send(1'b1, i == 15, 9'h130 + 9'(i), {i[3:0], ~i[3:0]});
    wait_done();
    chk(dev_u.viol == 0, 1'b1);
    for (int i = 0; i < 16; i++) chk(dev_u.mem[9'h130 + i], {i[3:0], ~i[3:0]});
    rd(9'h13f, 8'hf0);
    $display("t_page done");
  endtask : t_page
  task automatic t_refuse();
    send(1'b1, 1'b0, 9'h050, 8'h11);
    send(1'b1, 1'b1, 9'h060, 8'h3c);
    chk(wt > 300, 1'b1);
    wait_done();
    chk(dev_u.viol == 0, 1'b1);
    chk(dev_u.mem[9'h050], 8'h11);
    chk(dev_u.mem[9'h060], 8'h3c);
    $display("t_refuse done");
  endtask : t_refuse
  initial begin
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    t_power();
    t_byte();
    t_page();
    t_refuse();
    summarize();
  end
endmodule : pep_host_tb
